/* testbench/gate_driver_fault_manager_bench.sv */
/*
 * Self-checking bench of the gate driver fault manager.
 * Assumes the bridge model on the gate side and an AXI4-Lite master here.
 */
`timescale 1ns/100ps
`default_nettype none
module gate_driver_fault_manager_bench
	import gdfm_pkg::*;
;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, temp_warn_cmp, temp_sd_cmp, driver_disable_pin;
	logic pin_config_strap, fault_indicator_pin_n, charge_pump_en;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb, gate_cmd, gate_cmp, stuck, drain_source_threshold;
	logic [1:0] s_axi_bresp, s_axi_rresp, ds_cmp, pwm_in, gate_pulldown_en, rr;
	logic [1:0] switch_node_pulldown_enable, switch_node_pullup_enable;
	logic [2:0] ds_level_pin_code;
	int failures, n_checks;
	gdfm_ctrl_t c;

	gdfm_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gate_cmd, .gate_cmp,
		.ds_cmp, .pwm_in, .temp_warn_cmp, .temp_sd_cmp, .driver_disable_pin,
		.pin_config_strap, .ds_level_pin_code, .fault_indicator_pin_n, .gate_pulldown_en,
		.charge_pump_en, .switch_node_pulldown_enable, .switch_node_pullup_enable,
		.drain_source_threshold);
	gdfm_bridge_model u_brg (.aclk, .gate_cmd, .stuck, .pd_en(switch_node_pulldown_enable),
		.pu_en(switch_node_pullup_enable), .gate_cmp, .ds_cmp);

	// Free-running 100 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task tally_and_finish;
		if (failures == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// Negedge waits keep samples clear of the design's own updates
	task cyc(input int n);
		repeat (n) @(negedge aclk);
	endtask : cyc

	// Both channels offered together, each dropped when taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, xa, xw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ta && tw))
		begin
			@(negedge aclk);
			xa = s_axi_awvalid && s_axi_awready;
			xw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= s_axi_awvalid && !xa;
			s_axi_wvalid <= s_axi_wvalid && !xw;
			ta = ta || xa;
			tw = tw || xw;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		rr = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask : rd

	task stat(input logic [31:0] e);
		rd(ADDR_STAT);
		chk(rv, e);
	endtask : stat

	task clr;
		c.clr = 1'b1;
		wr(ADDR_CTRL, 32'(c));
		c.clr = 1'b0;
		cyc(4);
	endtask : clr

	// Gate 0 commanded but held low; no fault inside the w-cycle drive window
	task gfault(input gdfm_mode_t m, input logic ind, input int w);
		c = '0;
		c.en = 1'b1;
		c.mode = m;
		c.ind = ind;
		wr(ADDR_CTRL, 32'(c));
		@(posedge aclk);
		stuck <= 4'h1;
		gate_cmd <= 4'h1;
		cyc(w - 5);
		chk(32'(fault_indicator_pin_n), 32'h00000001);
		cyc(30);
	endtask : gfault

	task unstick;
		@(posedge aclk);
		stuck <= 4'h0;
		gate_cmd <= 4'h0;
		cyc(6);
	endtask : unstick

	task t_gate;
		gfault(GDFM_LATCHED, 1'b0, 100);
		chk(32'(fault_indicator_pin_n), 32'h00000000);
		chk(32'(gate_pulldown_en), 32'h00000003);
		unstick();
		chk(32'(fault_indicator_pin_n), 32'h00000000);
		stat(32'h00000011);
		clr();
		chk(32'(fault_indicator_pin_n), 32'h00000001);
		stat(32'h00000000);
		rd(ADDR_CTRL);
		chk(rv, 32'(c));
		gfault(GDFM_CYCLE, 1'b1, 100);
		chk(32'(gate_pulldown_en), 32'h00000001);
		unstick();
		@(posedge aclk);
		pwm_in <= 2'h1;
		cyc(6);
		chk(32'(fault_indicator_pin_n), 32'h00000001);
		stat(32'h00000010);
		clr();
		gfault(GDFM_WARN, 1'b0, 100);
		chk(32'(gate_pulldown_en), 32'h00000000);
		unstick();
		stat(32'h00000012);
		clr();
		gfault(GDFM_OFF, 1'b0, 100);
		unstick();
		stat(32'h00000000);
	endtask : t_gate

	task t_therm;
		@(posedge aclk);
		temp_warn_cmp <= 1'b1;
		cyc(6);
		@(posedge aclk);
		temp_warn_cmp <= 1'b0;
		temp_sd_cmp <= 1'b1;
		cyc(6);
		chk(32'(charge_pump_en), 32'h00000000);
		chk(32'(gate_pulldown_en), 32'h00000003);
		@(posedge aclk);
		temp_sd_cmp <= 1'b0;
		cyc(6);
		chk(32'(fault_indicator_pin_n), 32'h00000000);
		stat(32'h0000000F);
		clr();
		stat(32'h00000000);
		chk(32'(charge_pump_en), 32'h00000001);
	endtask : t_therm

	// Host order: drivers off, threshold, sources, enable, read, undo
	task t_diag;
		c.en = 1'b0;
		wr(ADDR_CTRL, 32'(c));
		wr(ADDR_CFG, 32'h0000000A);
		wr(ADDR_DIAG, 32'h00000008);
		cyc(4);
		chk(32'(drain_source_threshold), 32'h0000000A);
		chk(32'(switch_node_pullup_enable), 32'h00000000);
		wr(ADDR_DIAG, 32'h00000009);
		cyc(4);
		chk(32'(switch_node_pullup_enable), 32'h00000001);
		stat(32'h00000100);
		wr(ADDR_DIAG, 32'h0000000D);
		cyc(4);
		chk(32'(switch_node_pulldown_enable), 32'h00000002);
		stat(32'h00000100);
		wr(ADDR_DIAG, 32'h0000000B);
		cyc(4);
		stat(32'h00000000);
		wr(ADDR_DIAG, 32'h00000001);
		wr(ADDR_DIAG, 32'h00000000);
		c.en = 1'b1;
		wr(ADDR_CTRL, 32'(c));
		rd(8'h10);
		chk(32'(rr), 32'(RESP_SLVERR));
		chk(rv, 32'h00000000);
		wr(8'h10, 32'h00000001);
		chk(32'(rr), 32'(RESP_SLVERR));
		wr(ADDR_STAT, 32'h00000001);
		chk(32'(rr), 32'(RESP_OKAY));
		// Disable pin forces pull-downs while the drivers are enabled
		@(posedge aclk);
		driver_disable_pin <= 1'b1;
		cyc(4);
		chk(32'(gate_pulldown_en), 32'h00000003);
		@(posedge aclk);
		driver_disable_pin <= 1'b0;
		cyc(4);
		chk(32'(gate_pulldown_en), 32'h00000000);
	endtask : t_diag

	// Pin variant: no warning, no diagnostics, self-recovering shutdown
	task t_pin;
		@(posedge aclk);
		aresetn <= 1'b0;
		pin_config_strap <= 1'b1;
		cyc(2);
		@(posedge aclk);
		aresetn <= 1'b1;
		cyc(8);
		@(posedge aclk);
		temp_warn_cmp <= 1'b1;
		temp_sd_cmp <= 1'b1;
		cyc(6);
		chk(32'(fault_indicator_pin_n), 32'h00000000);
		@(posedge aclk);
		temp_warn_cmp <= 1'b0;
		temp_sd_cmp <= 1'b0;
		cyc(6);
		chk(32'(fault_indicator_pin_n), 32'h00000001);
		chk(32'(charge_pump_en), 32'h00000001);
		stat(32'h00001000);
		wr(ADDR_DIAG, 32'h00000009);
		cyc(4);
		chk(32'(switch_node_pullup_enable), 32'h00000000);
		gfault(GDFM_LATCHED, 1'b0, 400);
		chk(32'(gate_pulldown_en), 32'h00000001);
		unstick();
		@(posedge aclk);
		pwm_in <= 2'h0;
		cyc(6);
		chk(32'(fault_indicator_pin_n), 32'h00000001);
		// Level six on the threshold pin silences the gate monitor
		@(posedge aclk);
		ds_level_pin_code <= DS_LEVEL_OFF;
		gfault(GDFM_LATCHED, 1'b0, 400);
		chk(32'(fault_indicator_pin_n), 32'h00000001);
		chk(32'(gate_pulldown_en), 32'h00000000);
		unstick();
	endtask : t_pin

	// Main sequence
	initial
	begin
		failures = 0;
		n_checks = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		{gate_cmd, stuck, pwm_in, temp_warn_cmp, temp_sd_cmp} = '0;
		{driver_disable_pin, pin_config_strap, ds_level_pin_code} = '0;
		c = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		cyc(6);
		chk(32'(gate_pulldown_en), 32'h00000003);
		stat(32'h00000000);
		t_gate();
		t_therm();
		t_diag();
		t_pin();
		tally_and_finish();
	end

	// Watchdog well beyond the few thousand cycles of the run
	initial
	begin
		#400000;
		failures++;
		tally_and_finish();
	end
endmodule : gate_driver_fault_manager_bench
`default_nettype wire

/* testbench/gdfm_bridge_model.sv */
/*
 * Behavioural half-bridge pair with gate and switch-node comparators.
 * Assumes gate 2h is the high side, 2h+1 the low side; one clock.
 */
`timescale 1ns/100ps
`default_nettype none
module gdfm_bridge_model
(
	input wire logic aclk,
	input wire logic [3:0] gate_cmd,
	input wire logic [3:0] stuck,
	input wire logic [1:0] pd_en,
	input wire logic [1:0] pu_en,
	output logic [3:0] gate_cmp,
	output logic [1:0] ds_cmp
);
	// Gate follows its command a cycle late; a stuck gate never rises
	always_ff @(posedge aclk)
	begin
		gate_cmp <= gate_cmd & ~stuck;
	end
	// Open load: pull-up alone lifts the node, pull-down wins a fight
	assign ds_cmp = pu_en & ~pd_en;
endmodule : gdfm_bridge_model
`default_nettype wire

/* verilog/gdfm_drive_timer.sv */
/*
 * Gate drive window timer for one gate.
 * Assumes cmd and cmp are already synchronised to aclk.
 */
`timescale 1ns/100ps
`default_nettype none
module gdfm_drive_timer
	import gdfm_pkg::*;
#(
	parameter int CW = TCNT_W
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cmd,
	input wire logic cmp,
	input wire logic [CW-1:0] window,
	output logic timeout
);
	logic [CW-1:0] count;
	wire mismatch = cmd != cmp;
	wire expired = count >= (window - CW'(1));

	// Count while the gate lags its command
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !mismatch)
		begin
			count <= '0;
			timeout <= 1'b0;
		end
		else
		begin
			if (!expired)
				count <= count + CW'(1);
			timeout <= expired;
		end
	end

	// Lagging gate reports after the window
	property p_window;
		@(posedge aclk) disable iff (!aresetn)
		$rose(timeout) |-> $past(mismatch) && $past(expired);
	endproperty
	a_window: assert property (p_window) else $error("gate timeout without full window");
endmodule : gdfm_drive_timer
`default_nettype wire

/* verilog/gdfm_pkg.sv */
/*
 * Shared constants and types of the gate driver fault manager.
 * Assumes a 100 MHz device clock and a 32-bit AXI4-Lite register bus.
 */
`default_nettype none
package gdfm_pkg;
	// Clock and drive time window choices
	localparam int CLK_PERIOD_NS = 10;
	localparam int TDRV_1US_NS = 1000;
	localparam int TDRV_2US_NS = 2000;
	localparam int TDRV_4US_NS = 4000;
	localparam int TDRV_8US_NS = 8000;
	localparam int TCNT_W = 10;
	localparam logic [1:0] TDRV_SEL_HW = 2'h2;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DIAG = 8'h04;
	localparam logic [7:0] ADDR_CFG = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0C;
	localparam int ADDR_W = 8;

	// Status word field positions
	localparam int ST_FAULT = 0;
	localparam int ST_WARN = 1;
	localparam int ST_OTW = 2;
	localparam int ST_THERMAL_SHUTDOWN_FLAG = 3;
	localparam int ST_GVF_LSB = 4;
	localparam int ST_DS_LSB = 8;
	localparam int ST_HW = 12;

	// Diag word field positions: enable, pull-downs, pull-ups
	localparam int DG_EN = 0;
	localparam int DG_PD_LSB = 1;
	localparam int DG_PU_LSB = 3;
	localparam int DG_W = 5;
	localparam int CFG_W = 4;

	// Pin decode level that switches gate protection off
	localparam logic [2:0] DS_LEVEL_OFF = 3'h6;
	localparam logic [1:0] BRG_INDEP = 2'h0;
	localparam logic [1:0] BRG_SPLIT = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		GDFM_LATCHED = 2'h0,
		GDFM_CYCLE = 2'h1,
		GDFM_WARN = 2'h2,
		GDFM_OFF = 2'h3
	} gdfm_mode_t;

	// Control word, bit 0 at the bottom
	typedef struct packed {
		logic [1:0] tdrv;
		logic [1:0] brg;
		logic ind;
		gdfm_mode_t mode;
		logic clr;
		logic en;
	} gdfm_ctrl_t;

	localparam int CTRL_W = 9;
	localparam logic [8:0] CTRL_RST = 9'h000;

	// Least time in whole cycles
	function automatic logic [TCNT_W-1:0] ns_to_cyc(input int ns);
		return TCNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	endfunction : ns_to_cyc
endpackage : gdfm_pkg
`default_nettype wire

/* verilog/gdfm_top.sv */
/*
 * Gate driver fault manager: gate voltage, thermal and offline
 * diagnostic supervision with an AXI4-Lite register slave.
 * Assumes all comparator and PWM inputs are asynchronous pins.
 */
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Gate that misses its comparator level past the drive window flags a fault.
// - Independent or split bridge modes may shut only the faulty half-bridge.
// - Latched mode pulls gates down, raises fault, holds all until clear.
// - Cycle mode acts latched but next PWM edge releases fault and drive.
// - Warning mode sets warn and gate bit only, held until clear.
// - Disabled mode neither reacts nor reports.
// - Pin variant fixes cycle mode, 4 us window, per-bridge shutdown in independent or split bridge mode.
// - Pin variant turns gate protection off at threshold pin level six.
// - Over warning temperature sets warn and thermal warning, held until clear.
// - Shutdown temperature pulls gates down, stops pump, latches fault.
// - Pin variant recovers from thermal shutdown by itself.
// - Diagnostic enable gates the per-node pull-up and pull-down sources.
// - During diagnostics drain-source status follows the live comparator.
// - Pin variant has no thermal warning and no diagnostics.
// - Register variant selects one of four gate fault modes.
// - Clear command clears ended faults and then returns to zero.
module gdfm_top
	import gdfm_pkg::*;
#(
	parameter int NHB = 2
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2*NHB-1:0] gate_cmd,
	input wire logic [2*NHB-1:0] gate_cmp,
	input wire logic [NHB-1:0] ds_cmp,
	input wire logic [NHB-1:0] pwm_in,
	input wire logic temp_warn_cmp,
	input wire logic temp_sd_cmp,
	input wire logic driver_disable_pin,
	input wire logic pin_config_strap,
	input wire logic [2:0] ds_level_pin_code,
	output logic fault_indicator_pin_n,
	output logic [NHB-1:0] gate_pulldown_en,
	output logic charge_pump_en,
	output logic [NHB-1:0] switch_node_pulldown_enable,
	output logic [NHB-1:0] switch_node_pullup_enable,
	output logic [CFG_W-1:0] drain_source_threshold
);
	localparam int NG = 2 * NHB;
	localparam int SW = 2 * NG + 2 * NHB + 7;

	// Two-flop synchronisers for every pin input
	logic [SW-1:0] sync_a;
	logic [SW-1:0] sync_b;
	wire [SW-1:0] pins_raw = {gate_cmd, gate_cmp, ds_cmp, pwm_in, temp_warn_cmp,
		temp_sd_cmp, driver_disable_pin, pin_config_strap, ds_level_pin_code};
	always_ff @(posedge aclk)
	begin
		sync_a <= pins_raw;
		sync_b <= sync_a;
	end

	logic [NG-1:0] cmd_s;
	logic [NG-1:0] cmp_s;
	logic [NHB-1:0] ds_s;
	logic [NHB-1:0] pwm_s;
	logic otw_s;
	logic thermal_shutdown_flag_s;
	logic driver_disable_pin_s;
	logic strap_s;
	logic [2:0] lvl_s;
	assign {cmd_s, cmp_s, ds_s, pwm_s, otw_s, thermal_shutdown_flag_s, driver_disable_pin_s, strap_s, lvl_s} = sync_b;

	// Strap caught once the synchroniser holds real pin data
	logic [1:0] strap_cnt;
	logic hw;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			strap_cnt <= 2'h0;
		else if (strap_cnt != 2'h3)
			strap_cnt <= strap_cnt + 2'h1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			hw <= 1'b0;
		else if (strap_cnt == 2'h2)
			hw <= strap_s;
	end

	// Register storage
	gdfm_ctrl_t ctrl;
	logic [DG_W-1:0] diag;
	logic [CFG_W-1:0] cfg;

	// Effective configuration
	// pin variant fixed settings
	wire gdfm_mode_t mode = hw ? GDFM_CYCLE : ctrl.mode;
	wire [1:0] tsel = hw ? TDRV_SEL_HW : ctrl.tdrv;
	wire per_hb = (ctrl.brg == BRG_INDEP || ctrl.brg == BRG_SPLIT) && (hw || ctrl.ind);
	wire gate_dis = mode == GDFM_OFF || (hw && lvl_s == DS_LEVEL_OFF);
	wire protect = mode == GDFM_LATCHED || mode == GDFM_CYCLE;
	wire clr_pulse = ctrl.clr && !hw;
	wire drv_en = hw || ctrl.en;

	// Drive window selection
	logic [TCNT_W-1:0] window;
	always_comb
	begin
		unique case (tsel)
			2'h0: window = ns_to_cyc(TDRV_1US_NS);
			2'h1: window = ns_to_cyc(TDRV_2US_NS);
			2'h2: window = ns_to_cyc(TDRV_4US_NS);
			2'h3: window = ns_to_cyc(TDRV_8US_NS);
		endcase
	end

	// One window timer per gate
	logic [NG-1:0] timeout;
	for (genvar g = 0; g < NG; g++)
	begin : g_tmr
		gdfm_drive_timer #(.CW(TCNT_W)) u_tmr (
			.aclk(aclk),
			.aresetn(aresetn),
			.cmd(cmd_s[g]),
			.cmp(cmp_s[g]),
			.window(window),
			.timeout(timeout[g])
		);
	end

	wire [NG-1:0] detect = gate_dis ? '0 : timeout;
	logic [NHB-1:0] pwm_d;
	always_ff @(posedge aclk)
		pwm_d <= pwm_s;
	wire pwm_edge = |(pwm_s ^ pwm_d);

	// Fault flags; a new event wins over any clear
	logic [NG-1:0] gvf;
	logic [NHB-1:0] hold;
	logic warn_gate;
	logic thermal_warning_flag;
	logic thermal_shutdown_flag;
	logic [NHB-1:0] hb_detect;
	logic [NHB-1:0] hb_cond;
	always_comb
	begin
		for (int h = 0; h < NHB; h++)
		begin
			hb_detect[h] = |detect[2*h +: 2];
			hb_cond[h] = |timeout[2*h +: 2];
		end
	end
	wire [NHB-1:0] hold_rel = (mode == GDFM_CYCLE && pwm_edge) ? '1 :
		(clr_pulse ? ~hb_cond : '0);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			gvf <= '0;
			hold <= '0;
			warn_gate <= 1'b0;
		end
		else
		begin
			gvf <= detect | (gvf & ~(clr_pulse ? ~timeout : '0));
			hold <= (protect ? hb_detect : '0) | (hold & ~hold_rel);
			warn_gate <= (mode == GDFM_WARN && |detect) || (warn_gate && !clr_pulse);
		end
	end

	// Thermal flags
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			thermal_warning_flag <= 1'b0;
			thermal_shutdown_flag <= 1'b0;
		end
		else
		begin
			thermal_warning_flag <= (otw_s && !hw) || (thermal_warning_flag && !hw && !(clr_pulse && !otw_s));
			thermal_shutdown_flag <= thermal_shutdown_flag_s || (thermal_shutdown_flag && !(hw || clr_pulse));
		end
	end

	wire fault_any = |hold || thermal_shutdown_flag;
	wire warn_any = warn_gate || thermal_warning_flag;

	wire [NHB-1:0] hb_off = per_hb ? hold : {NHB{|hold}};
	wire diag_on = diag[DG_EN] && !hw;
	wire [NHB-1:0] next_pd = diag_on ? diag[DG_PD_LSB +: NHB] : '0;
	wire [NHB-1:0] next_pu = diag_on ? diag[DG_PU_LSB +: NHB] : '0;
	wire [NHB-1:0] ds_status = diag_on ? ds_s : '0;
	wire [NHB-1:0] next_gpd = hb_off | {NHB{thermal_shutdown_flag || driver_disable_pin_s || !drv_en}};

	// Registered pin-side outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fault_indicator_pin_n <= 1'b1;
			gate_pulldown_en <= '1;
			charge_pump_en <= 1'b0;
			switch_node_pulldown_enable <= '0;
			switch_node_pullup_enable <= '0;
		end
		else
		begin
			fault_indicator_pin_n <= !fault_any;
			gate_pulldown_en <= next_gpd;
			charge_pump_en <= !thermal_shutdown_flag;
			switch_node_pulldown_enable <= next_pd;
			switch_node_pullup_enable <= next_pu;
		end
	end
	assign drain_source_threshold = cfg;

	// Status word
	wire [31:0] stat = 32'(ds_status) << ST_DS_LSB | 32'(gvf) << ST_GVF_LSB |
		32'(hw) << ST_HW | 32'(thermal_shutdown_flag) << ST_THERMAL_SHUTDOWN_FLAG | 32'(thermal_warning_flag) << ST_OTW |
		32'(warn_any) << ST_WARN | 32'(fault_any) << ST_FAULT;

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction : merge

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return a == ADDR_CTRL || a == ADDR_DIAG || a == ADDR_CFG || a == ADDR_STAT;
	endfunction : mapped

	// Write channel: address and data captured in either order
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_go = aw_held && w_held && !s_axi_bvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held && !aw_take;
			s_axi_wready <= !w_held && !w_take;
			if (aw_take)
				aw_held <= 1'b1;
			if (w_take)
				w_held <= 1'b1;
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	always_ff @(posedge aclk)
	begin
		if (aw_take)
			aw_addr <= s_axi_awaddr;
		if (w_take)
		begin
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
	end

	// Register writes; clear bit drops one cycle after it acts
	wire [31:0] ctrl_new = merge(32'(ctrl), w_data, w_strb);
	wire [31:0] diag_new = merge(32'(diag), w_data, w_strb);
	wire [31:0] cfg_new = merge(32'(cfg), w_data, w_strb);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= gdfm_ctrl_t'(CTRL_RST);
			diag <= '0;
			cfg <= '0;
		end
		else
		begin
			ctrl.clr <= 1'b0;
			if (wr_go && aw_addr == ADDR_CTRL)
				ctrl <= gdfm_ctrl_t'(ctrl_new[CTRL_W-1:0]);
			if (wr_go && aw_addr == ADDR_DIAG)
				diag <= diag_new[DG_W-1:0];
			if (wr_go && aw_addr == ADDR_CFG)
				cfg <= cfg_new[CFG_W-1:0];
		end
	end

	// Read channel, one cycle after the address is taken
	logic [31:0] rd_mux;
	always_comb
	begin
		unique case (s_axi_araddr)
			ADDR_CTRL: rd_mux = 32'(ctrl);
			ADDR_DIAG: rd_mux = 32'(diag);
			ADDR_CFG: rd_mux = 32'(cfg);
			ADDR_STAT: rd_mux = stat;
			default: rd_mux = 32'h0000_0000;
		endcase
	end
	wire ar_take = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (ar_take)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Checks next to the logic
	property p_gvf_set;
		@(posedge aclk) disable iff (!aresetn)
		$rose(timeout[0]) && !gate_dis |=> gvf[0];
	endproperty
	a_gvf_set: assert property (p_gvf_set) else $error("gate fault not flagged");

	property p_latched;
		@(posedge aclk) disable iff (!aresetn)
		hold[0] && mode == GDFM_LATCHED && !clr_pulse |=> hold[0] ##1 !fault_indicator_pin_n;
	endproperty
	a_latched: assert property (p_latched) else $error("latched hold lost");

	property p_cycle;
		@(posedge aclk) disable iff (!aresetn)
		hold[0] && mode == GDFM_CYCLE && pwm_edge && !hb_detect[0] |=> !hold[0];
	endproperty
	a_cycle: assert property (p_cycle) else $error("pwm edge did not release");

	property p_warn;
		@(posedge aclk) disable iff (!aresetn)
		mode == GDFM_WARN && |detect && hold == '0 |=> warn_gate && hold == '0;
	endproperty
	a_warn: assert property (p_warn) else $error("warning mode acted");

	property p_off;
		@(posedge aclk) disable iff (!aresetn)
		gate_dis && !gvf[0] |=> !gvf[0];
	endproperty
	a_off: assert property (p_off) else $error("disabled monitor reported");

	property p_otw;
		@(posedge aclk) disable iff (!aresetn)
		otw_s && !hw |=> thermal_warning_flag ##1 stat[ST_WARN];
	endproperty
	a_otw: assert property (p_otw) else $error("thermal warning missed");

	property p_thermal_shutdown_flag;
		@(posedge aclk) disable iff (!aresetn)
		thermal_shutdown_flag |=> !charge_pump_en && !fault_indicator_pin_n && gate_pulldown_en == '1;
	endproperty
	a_thermal_shutdown_flag: assert property (p_thermal_shutdown_flag) else $error("shutdown response missing");

	property p_diag_src;
		@(posedge aclk) disable iff (!aresetn)
		!diag_on |=> switch_node_pullup_enable == '0 && switch_node_pulldown_enable == '0;
	endproperty
	a_diag_src: assert property (p_diag_src) else $error("source on without diag");

	property p_ds_live;
		@(posedge aclk) disable iff (!aresetn)
		ar_take && s_axi_araddr == ADDR_STAT && diag_on
			|=> s_axi_rdata[ST_DS_LSB +: NHB] == $past(ds_s);
	endproperty
	a_ds_live: assert property (p_ds_live) else $error("ds status not live");

	property p_clr;
		@(posedge aclk) disable iff (!aresetn)
		ctrl.clr |=> !ctrl.clr || $past(wr_go);
	endproperty
	a_clr: assert property (p_clr) else $error("clear bit stuck");
endmodule : gdfm_top
`default_nettype wire
